// ---- usb_endpoint_fifo_and_suspend_ctrl.sv ----
// Notes on behaviour
// - bits 7..1 enable endpoint input pipes
// - rebuild bit reconfigures pipes, then self-clears
// - output pipe enables at bits 1, 4..7
// - toggle select picks DATA0/DATA1 first, alternating
// - two-bit depth code: 8,16,32,64 bytes
// - endpoints 2,3 input single or double buffer
// - eight byte-wide pipe registers, no reset value
// - idle over 3 ms: suspend, flag, interrupt
// - deeper sleep select lowers suspend current
// - host resume sets resume flag, raises interrupt
// - leaving suspend clears deeper sleep and resume
// - remote wake bit sends wake pulse
// - interrupt pulse on suspend, resume, reset, access
// - access flag interrupts only when pipe, enable set
// - suspend and resume bypass per-source enables
// - suspend and resume flags read-only to software
// - service needs module, global, related enables, stack
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module usb_endpoint_fifo_and_suspend_ctrl #(
  parameter int SUSPEND_CYCLES_P = usb_pipe_pkg::SUSPEND_CYCLES,
  parameter int WAKE_CYCLES_P = usb_pipe_pkg::WAKE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [usb_pipe_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [usb_pipe_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_activity_pin,
  input wire logic host_resume_pin,
  input wire logic bus_reset_pin,
  input wire logic [7:0] ep_access_strobe,
  input wire logic [7:0] packet_done,
  input wire logic rx_valid,
  input wire logic [2:0] rx_ep,
  input wire logic [7:0] rx_data,
  input wire logic mcu_global_int_en,
  input wire logic mcu_usb_int_en,
  input wire logic mcu_stack_full,
  output logic usb_clock_enable,
  output logic deep_suspend_active,
  output logic remote_wake_drive,
  output logic usb_irq_pulse,
  output logic usb_irq_service,
  output logic [7:0] in_pipe_active,
  output logic [7:0] out_pipe_active,
  output logic [13:0] ep_depth_code,
  output logic [48:0] ep_depth_bytes,
  output logic [1:0] in_double_buffer,
  output logic layout_busy,
  output logic [7:0] data_toggle,
  output logic fifo_request,
  output logic [2:0] fifo_select,
  output logic tx_valid,
  output logic [2:0] tx_ep,
  output logic [7:0] tx_data
);
  import usb_pipe_pkg::*;

  localparam int WAKE_W = $clog2(WAKE_CYCLES_P + 1);
  localparam int REB_W = $clog2(REBUILD_CYCLES + 1);

  // configuration registers
  logic [7:1] in_en_reg;
  logic pipe_layout_rebuild_reg;
  logic [REB_W-1:0] rebuild_cnt_reg;
  logic [7:0] out_en_reg;
  logic [7:2] size_lo_reg;
  logic [7:0] size_hi_reg;
  logic [3:0] buf_sel_reg;
  logic [7:0] act_in_reg;
  logic [7:0] act_out_reg;
  logic [13:0] act_size_reg;
  logic [1:0] act_dbl_reg;
  // status and control
  link_state_e state_reg;
  logic bus_idle_sleep_flag_reg;
  logic resume_flag_reg;
  logic bus_reset_flag_reg;
  logic usb_int_en_reg;
  logic usb_clock_gate_reg;
  logic deeper_sleep_select_reg;
  logic [WAKE_W-1:0] wake_cnt_reg;
  logic wake_drive_reg;
  logic [7:0] ep_flag_reg;
  logic [7:0] ep_ie_reg;
  logic [2:0] pipe_sel_reg;
  logic request_reg;
  logic [7:0] toggle_reg;
  logic [7:0] pipe_reg [NUM_EP];
  logic irq_reg;
  logic tx_valid_reg;
  logic [2:0] tx_ep_reg;
  logic [7:0] tx_data_reg;
  // pin synchronisers: meta stage feeds only the sync stage
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic reset_prev_reg;
  // bus slave
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic act_sync;
  logic resume_sync;
  logic reset_sync;
  logic idle_expired;
  logic wr_fire;
  logic wr_en;
  logic [31:0] rd_word;
  logic bus_idle_sleep_flag_set;
  logic resume_set;
  logic leave_suspend;
  logic reset_rise;
  logic req_start;
  logic [7:0] ep_pipe_on;
  logic [7:0] ep_irq_hit;
  logic [7:0] ep_flag_clear;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0) && ((a <= ADDR_PIPE_SEL) || (a[7:5] == PIPE_REGION));
    return hit;
  endfunction : addr_mapped

  function automatic logic is_pipe(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0) && (a[7:5] == PIPE_REGION);
    return hit;
  endfunction : is_pipe

  assign act_sync = pin_sync_reg[0];
  assign resume_sync = pin_sync_reg[1];
  assign reset_sync = pin_sync_reg[2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      reset_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {bus_reset_pin, host_resume_pin, bus_activity_pin};
      pin_sync_reg <= pin_meta_reg;
      reset_prev_reg <= reset_sync;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_en = wr_fire && wstrb0_reg && addr_mapped(awaddr_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_IN_EN: rd_word = {24'h00_0000, in_en_reg, pipe_layout_rebuild_reg};
      ADDR_OUT_EN: rd_word = {24'h00_0000, out_en_reg};
      ADDR_SIZE_LO: rd_word = {24'h00_0000, size_lo_reg, 2'h0};
      ADDR_SIZE_HI: rd_word = {24'h00_0000, size_hi_reg};
      ADDR_BUF_SEL: rd_word = {28'h000_0000, buf_sel_reg};
      ADDR_STATUS: rd_word = {27'h000_0000, usb_int_en_reg, bus_reset_flag_reg, wake_drive_reg,
                              resume_flag_reg, bus_idle_sleep_flag_reg};
      ADDR_CLK_CTRL: rd_word = {30'h0000_0000, deeper_sleep_select_reg, usb_clock_gate_reg};
      ADDR_EP_FLAGS: rd_word = {24'h00_0000, ep_flag_reg};
      ADDR_EP_IE: rd_word = {24'h00_0000, ep_ie_reg};
      ADDR_PIPE_SEL: rd_word = {26'h000_0000, pipe_layout_rebuild_reg, request_reg, 1'b0, pipe_sel_reg};
      default: begin
        if (is_pipe(s_axi_araddr)) begin
          rd_word = {24'h00_0000, pipe_reg[s_axi_araddr[4:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // pipe configuration registers, all zero after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_en_reg <= 7'h00;
      out_en_reg <= REG_RESET;
      size_lo_reg <= 6'h00;
      size_hi_reg <= REG_RESET;
      buf_sel_reg <= 4'h0;
      ep_ie_reg <= REG_RESET;
      pipe_sel_reg <= 3'h0;
      request_reg <= 1'b0;
    end else if (wr_en) begin
      case (awaddr_reg)
        ADDR_IN_EN: in_en_reg <= wdata_reg[7:1];
        ADDR_OUT_EN: out_en_reg <= wdata_reg;
        ADDR_SIZE_LO: size_lo_reg <= wdata_reg[7:2];
        ADDR_SIZE_HI: size_hi_reg <= wdata_reg;
        ADDR_BUF_SEL: buf_sel_reg <= wdata_reg[3:0];
        ADDR_EP_IE: ep_ie_reg <= wdata_reg;
        ADDR_PIPE_SEL: begin
          pipe_sel_reg <= wdata_reg[2:0];
          request_reg <= wdata_reg[PS_REQ_BIT];
        end
        default: ;
      endcase
    end
  end

  // rebuild: self-clearing, applies the layout after a short settle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe_layout_rebuild_reg <= 1'b0;
      rebuild_cnt_reg <= '0;
      act_in_reg <= REG_RESET;
      act_out_reg <= REG_RESET;
      act_size_reg <= 14'h0000;
      act_dbl_reg <= 2'h0;
    end else if (wr_en && awaddr_reg == ADDR_IN_EN && wdata_reg[IN_REBUILD_BIT]) begin
      pipe_layout_rebuild_reg <= 1'b1;
      rebuild_cnt_reg <= REB_W'(REBUILD_CYCLES - 1);
    end else if (pipe_layout_rebuild_reg) begin
      if (rebuild_cnt_reg == '0) begin
        pipe_layout_rebuild_reg <= 1'b0;
        act_in_reg <= {in_en_reg, 1'b0};
        act_out_reg <= out_en_reg & OUT_EN_MASK;
        act_size_reg <= {size_hi_reg, size_lo_reg};
        act_dbl_reg <= {buf_sel_reg[2], buf_sel_reg[0]};
      end else begin
        rebuild_cnt_reg <= rebuild_cnt_reg - REB_W'(1);
      end
    end
  end

  assign in_pipe_active = act_in_reg;
  assign out_pipe_active = act_out_reg;
  assign ep_depth_code = act_size_reg;
  assign in_double_buffer = act_dbl_reg;
  assign layout_busy = pipe_layout_rebuild_reg;
  assign fifo_request = request_reg;
  assign fifo_select = pipe_sel_reg;
  assign data_toggle = toggle_reg;
  assign req_start = wr_en && awaddr_reg == ADDR_PIPE_SEL && wdata_reg[PS_REQ_BIT] && !request_reg;
  assign ep_flag_clear = (wr_en && awaddr_reg == ADDR_EP_FLAGS) ? wdata_reg : 8'h00;

  genvar gi;
  generate
    for (gi = 1; gi < NUM_EP; gi++) begin : g_depth
      assign ep_depth_bytes[(gi-1)*DEPTH_W +: DEPTH_W] =
        DEPTH_BASE_BYTES << act_size_reg[(gi-1)*2 +: 2];
    end
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      assign ep_pipe_on[gi] = (gi == 0) || act_in_reg[gi] || act_out_reg[gi];
      assign ep_irq_hit[gi] = ep_access_strobe[gi] && ep_pipe_on[gi] && ep_ie_reg[gi];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ep_flag_reg[gi] <= 1'b0;
        end else if (ep_access_strobe[gi]) begin
          ep_flag_reg[gi] <= 1'b1;
        end else if (ep_flag_clear[gi]) begin
          ep_flag_reg[gi] <= 1'b0;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          toggle_reg[gi] <= 1'b0;
        end else if (req_start && wdata_reg[2:0] == 3'(gi)) begin
          toggle_reg[gi] <= out_en_reg[OUT_TOGGLE_BIT];
        end else if (packet_done[gi]) begin
          toggle_reg[gi] <= !toggle_reg[gi];
        end
      end
    end
  endgenerate

  // data pipes hold no reset value; receive side wins a same-cycle clash
  always_ff @(posedge aclk) begin
    if (rx_valid) begin
      pipe_reg[rx_ep] <= rx_data;
    end else if (wr_en && is_pipe(awaddr_reg)) begin
      pipe_reg[awaddr_reg[4:2]] <= wdata_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid_reg <= 1'b0;
      tx_ep_reg <= 3'h0;
      tx_data_reg <= 8'h00;
    end else begin
      tx_valid_reg <= wr_en && is_pipe(awaddr_reg);
      if (wr_en && is_pipe(awaddr_reg)) begin
        tx_ep_reg <= awaddr_reg[4:2];
        tx_data_reg <= wdata_reg;
      end
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_ep = tx_ep_reg;
  assign tx_data = tx_data_reg;

  // suspend detection
  bus_idle_timer #(
    .IDLE_CYCLES(SUSPEND_CYCLES_P)
  ) u_idle (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_reg == LINK_ACTIVE),
    .activity(act_sync),
    .expired(idle_expired)
  );

  assign bus_idle_sleep_flag_set = state_reg == LINK_ACTIVE && idle_expired;
  assign resume_set = state_reg == LINK_SUSPENDED && resume_sync && !resume_flag_reg;
  assign leave_suspend = state_reg == LINK_SUSPENDED && resume_flag_reg && usb_clock_gate_reg &&
                         act_sync && !resume_sync;
  assign reset_rise = reset_sync && !reset_prev_reg;

  // flags set and cleared by the link engine only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= LINK_ACTIVE;
      bus_idle_sleep_flag_reg <= 1'b0;
      resume_flag_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        LINK_ACTIVE: begin
          if (bus_idle_sleep_flag_set) begin
            state_reg <= LINK_SUSPENDED;
            bus_idle_sleep_flag_reg <= 1'b1;
          end
        end
        LINK_SUSPENDED: begin
          if (resume_set) begin
            resume_flag_reg <= 1'b1;
          end else if (leave_suspend) begin
            state_reg <= LINK_ACTIVE;
            bus_idle_sleep_flag_reg <= 1'b0;
            resume_flag_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_clock_gate_reg <= 1'b0;
      deeper_sleep_select_reg <= 1'b0;
    end else begin
      if (wr_en && awaddr_reg == ADDR_CLK_CTRL) begin
        usb_clock_gate_reg <= wdata_reg[CK_GATE_BIT];
        deeper_sleep_select_reg <= wdata_reg[CK_DEEP_BIT];
      end
      // leaving suspend wins over a same-cycle write
      if (leave_suspend) begin
        deeper_sleep_select_reg <= 1'b0;
      end
    end
  end

  assign usb_clock_enable = usb_clock_gate_reg;
  assign deep_suspend_active = bus_idle_sleep_flag_reg && deeper_sleep_select_reg;

  // status control: wake pulse, reset flag, module interrupt enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt_reg <= '0;
      wake_drive_reg <= 1'b0;
      bus_reset_flag_reg <= 1'b0;
      usb_int_en_reg <= 1'b0;
    end else begin
      if (wr_en && awaddr_reg == ADDR_STATUS && wdata_reg[ST_WAKE_BIT] && !wake_drive_reg) begin
        wake_cnt_reg <= WAKE_W'(WAKE_CYCLES_P - 1);
        wake_drive_reg <= 1'b1;
      end else if (wake_cnt_reg != '0) begin
        wake_cnt_reg <= wake_cnt_reg - WAKE_W'(1);
      end else begin
        wake_drive_reg <= 1'b0;
      end
      if (reset_rise) begin
        bus_reset_flag_reg <= 1'b1;
      end else if (wr_en && awaddr_reg == ADDR_STATUS && wdata_reg[ST_RESET_BIT]) begin
        bus_reset_flag_reg <= 1'b0;
      end
      if (wr_en && awaddr_reg == ADDR_STATUS) begin
        usb_int_en_reg <= wdata_reg[ST_INT_EN_BIT];
      end
    end
  end

  assign remote_wake_drive = wake_drive_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= bus_idle_sleep_flag_set || resume_set || reset_rise || (|ep_irq_hit);
    end
  end

  assign usb_irq_pulse = irq_reg;
  assign usb_irq_service = irq_reg && usb_int_en_reg && mcu_global_int_en && mcu_usb_int_en &&
                           !mcu_stack_full;
endmodule : usb_endpoint_fifo_and_suspend_ctrl

// ---- usb_pipe_pkg.sv ----
package usb_pipe_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int SUSPEND_CYCLES = SUSPEND_IDLE_MS * (CLK_HZ / 1000);
  localparam int WAKE_PULSE_US = 1000;
  localparam int WAKE_CYCLES = WAKE_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int REBUILD_CYCLES = 4;
  localparam int NUM_EP = 8;
  localparam int ADDR_W = 8;
  localparam int DEPTH_W = 7;

  localparam logic [ADDR_W-1:0] ADDR_IN_EN = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OUT_EN = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SIZE_LO = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SIZE_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_BUF_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_EP_FLAGS = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_EP_IE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_PIPE_SEL = 8'h24;
  localparam logic [2:0] PIPE_REGION = 3'h2;

  localparam int IN_REBUILD_BIT = 0;
  localparam int OUT_TOGGLE_BIT = 0;
  localparam logic [7:0] OUT_EN_MASK = 8'hF2;
  localparam int ST_BUS_IDLE_SLEEP_FLAG_BIT = 0;
  localparam int ST_RESUME_BIT = 1;
  localparam int ST_WAKE_BIT = 2;
  localparam int ST_RESET_BIT = 3;
  localparam int ST_INT_EN_BIT = 4;
  localparam int CK_GATE_BIT = 0;
  localparam int CK_DEEP_BIT = 1;
  localparam int PS_REQ_BIT = 4;
  localparam int PS_BUSY_BIT = 5;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [DEPTH_W-1:0] DEPTH_BASE_BYTES = 7'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {LINK_ACTIVE, LINK_SUSPENDED} link_state_e;
endpackage : usb_pipe_pkg

// ---- bus_idle_timer.sv ----
`timescale 1ns/1ps
module bus_idle_timer #(
  parameter int IDLE_CYCLES = 60000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic activity,
  output logic expired
);
  localparam int CNT_W = $clog2(IDLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(IDLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] DONE = CNT_W'(IDLE_CYCLES);

  logic [CNT_W-1:0] count_reg;

  // restart on any activity, fire once after a full idle span
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!run || activity) begin
        count_reg <= '0;
      end else if (count_reg == LAST) begin
        count_reg <= DONE;
        expired <= 1'b1;
      end else if (count_reg != DONE) begin
        count_reg <= count_reg + CNT_W'(1);
      end
    end
  end
endmodule : bus_idle_timer

// ---- usb_host_model.sv ----
`timescale 1ns/1ps
module usb_host_model (
  input wire logic aclk,
  input wire logic idle_req,
  input wire logic reset_req,
  input wire logic remote_wake_drive,
  output logic bus_activity_pin,
  output logic host_resume_pin,
  output logic bus_reset_pin
);
  logic wake_q;
  int resume_left;
  initial begin
    wake_q = 1'b0;
    resume_left = 0;
  end
  // answer the end of a wake pulse with resume signalling
  always @(posedge aclk) begin
    wake_q <= remote_wake_drive;
    if (wake_q && !remote_wake_drive) begin
      resume_left <= 6;
    end else if (resume_left > 0) begin
      resume_left <= resume_left - 1;
    end
  end
  assign host_resume_pin = resume_left > 0;
  assign bus_activity_pin = !idle_req;
  assign bus_reset_pin = reset_req;
endmodule : usb_host_model

// ---- usb_endpoint_fifo_and_suspend_ctrl_monitor.sv ----
`timescale 1ns/1ps
module usb_endpoint_fifo_and_suspend_ctrl_monitor #(
  parameter int WAKE_CYCLES_P = 20000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mcu_global_int_en,
  input wire logic mcu_usb_int_en,
  input wire logic mcu_stack_full,
  input wire logic bus_reset_pin,
  input wire logic [7:0] packet_done,
  input wire logic usb_clock_enable,
  input wire logic deep_suspend_active,
  input wire logic remote_wake_drive,
  input wire logic usb_irq_pulse,
  input wire logic usb_irq_service,
  input wire logic [7:0] in_pipe_active,
  input wire logic [7:0] out_pipe_active,
  input wire logic [13:0] ep_depth_code,
  input wire logic [48:0] ep_depth_bytes,
  input wire logic layout_busy,
  input wire logic [7:0] data_toggle
);
  logic [15:0] wake_len;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || !remote_wake_drive) begin
      wake_len <= '0;
    end else begin
      wake_len <= wake_len + 16'h0001;
    end
  end
  sequence rebuild_ends;
    ##[1:8] !layout_busy;
  endsequence
  sequence irq_soon;
    ##[1:6] usb_irq_pulse;
  endsequence
  a_service_gate: assert property (usb_irq_service |-> usb_irq_pulse && mcu_global_int_en
    && mcu_usb_int_en && !mcu_stack_full) else $error("service without all enables");
  a_rebuild_clears: assert property ($rose(layout_busy) |-> rebuild_ends)
    else $error("rebuild bit did not clear");
  a_pipe_masks: assert property (!in_pipe_active[0] && (out_pipe_active & 8'h0D) == 8'h00)
    else $error("pipe enable in unused position");
  a_depth_map: assert property (ep_depth_bytes[6:0] == (7'h08 << ep_depth_code[1:0])
    && ep_depth_bytes[48:42] == (7'h08 << ep_depth_code[13:12])) else $error("depth mismatch");
  a_wake_length: assert property ($fell(remote_wake_drive) |-> wake_len == 16'(WAKE_CYCLES_P))
    else $error("wake pulse length wrong");
  a_deep_leave: assert property ($fell(deep_suspend_active) |-> usb_clock_enable)
    else $error("left suspend with clock gated");
  a_toggle_flips: assert property (packet_done[1] |=> data_toggle[1] != $past(data_toggle[1]))
    else $error("toggle did not alternate");
  a_reset_irq: assert property ($rose(bus_reset_pin) |-> irq_soon)
    else $error("no interrupt after bus reset");
endmodule : usb_endpoint_fifo_and_suspend_ctrl_monitor
bind usb_endpoint_fifo_and_suspend_ctrl usb_endpoint_fifo_and_suspend_ctrl_monitor
  #(.WAKE_CYCLES_P(WAKE_CYCLES_P)) mon (.*);

// ---- usb_endpoint_fifo_and_suspend_ctrl_bench.sv ----
`timescale 1ns/1ps
module usb_endpoint_fifo_and_suspend_ctrl_bench;
  import usb_pipe_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_valid = 1'b0, idle_req = 1'b0, reset_req = 1'b0;
  logic mcu_global_int_en = 1'b1, mcu_usb_int_en = 1'b1, mcu_stack_full = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, ep_access_strobe = '0, packet_done = '0, rx_data = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] rx_ep = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, usb_clock_enable;
  logic deep_suspend_active, remote_wake_drive, usb_irq_pulse, usb_irq_service, layout_busy, fifo_request;
  logic tx_valid, bus_activity_pin, host_resume_pin, bus_reset_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, in_double_buffer, rresp_q;
  logic [2:0] wresp_q;
  logic [31:0] s_axi_rdata;
  logic [7:0] in_pipe_active, out_pipe_active, data_toggle, tx_data;
  logic [13:0] ep_depth_code;
  logic [48:0] ep_depth_bytes;
  logic [2:0] fifo_select, tx_ep;
  int failures = 0, checks = 0, waited;
  usb_endpoint_fifo_and_suspend_ctrl #(.SUSPEND_CYCLES_P(20), .WAKE_CYCLES_P(5)) dut (.*);
  usb_host_model host (.*);
  always #25 aclk = ~aclk;
  task conclude;
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    kb = 1'b0;
    waited = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!kb) begin
      @(negedge aclk);
      ka = s_axi_awvalid && s_axi_awready;
      kw = s_axi_wvalid && s_axi_wready;
      kb = s_axi_bvalid === 1'b1;
      wresp_q = {tx_valid, s_axi_bresp};
      @(posedge aclk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      if (kb) s_axi_bready <= 1'b0;
      if (++waited > 50) chk("write answer", 1, 0);
      if (waited > 50) conclude();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ka, kr;
    logic [31:0] d;
    kr = 1'b0;
    waited = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!kr) begin
      @(negedge aclk);
      ka = s_axi_arvalid && s_axi_arready;
      kr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      rresp_q = s_axi_rresp;
      @(posedge aclk);
      if (ka) s_axi_arvalid <= 1'b0;
      if (kr) s_axi_rready <= 1'b0;
      if (++waited > 50) chk("read answer", 1, 0);
      if (waited > 50) conclude();
    end
    chk("rdata", e, d);
  endtask : rd
  task automatic need(input int sel, input int lim, input bit want);
    bit hit;
    hit = 1'b0;
    for (waited = 0; waited < lim && !hit; waited++) begin
      @(negedge aclk);
      case (sel)
        0: hit = usb_irq_pulse === 1'b1;
        1: hit = layout_busy === 1'b0;
        default: hit = deep_suspend_active === 1'b0;
      endcase
    end
    chk("event seen", want, hit);
    if (want && !hit) conclude();
  endtask : need
  task reset_values;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
  endtask : reset_values
  task layout_cfg;
    wr(ADDR_OUT_EN, 32'hF3);
    wr(ADDR_SIZE_LO, 32'hE4);
    wr(ADDR_SIZE_HI, 32'h1B);
    wr(ADDR_BUF_SEL, 32'hF5);
    wr(ADDR_IN_EN, 32'hFF);
    need(1, 20, 1'b1);
    rd(ADDR_IN_EN, 32'hFE);
    rd(ADDR_BUF_SEL, 32'h05);
    chk("in pipes", 32'hFE, in_pipe_active);
    chk("out pipes", 32'hF2, out_pipe_active);
    chk("ep1 depth", 32'h10, ep_depth_bytes[6:0]);
    chk("ep3 depth", 32'h40, ep_depth_bytes[20:14]);
    chk("ep6 depth", 32'h10, ep_depth_bytes[41:35]);
    chk("double buffer", 32'h3, in_double_buffer);
  endtask : layout_cfg
  task suspend_entry;
    wr(ADDR_STATUS, 32'h10);
    idle_req <= 1'b1;
    repeat (15) @(posedge aclk);
    idle_req <= 1'b0;
    @(posedge aclk);
    idle_req <= 1'b1;
    need(0, 40, 1'b1);
    chk("suspend delay", 32'h1, waited >= 20 && waited <= 30);
    rd(ADDR_STATUS, 32'h11);
    wr(ADDR_STATUS, 32'h10);
    rd(ADDR_STATUS, 32'h11);
    wr(ADDR_CLK_CTRL, 32'h02);
    chk("clock and deep sleep", 32'h1, {usb_clock_enable, deep_suspend_active});
  endtask : suspend_entry
  task resume_wake;
    wr(ADDR_STATUS, 32'h14);
    need(0, 60, 1'b1);
    rd(ADDR_STATUS, 32'h13);
    wr(ADDR_CLK_CTRL, 32'h03);
    chk("clock gate", 32'h1, usb_clock_enable);
    idle_req <= 1'b0;
    need(2, 20, 1'b1);
    rd(ADDR_CLK_CTRL, 32'h01);
    rd(ADDR_STATUS, 32'h10);
  endtask : resume_wake
  task access_events;
    wr(ADDR_EP_IE, 32'h02);
    ep_access_strobe <= 8'h02;
    @(posedge aclk);
    ep_access_strobe <= 8'h00;
    need(0, 4, 1'b1);
    chk("service on", 32'h1, usb_irq_service);
    @(posedge aclk);
    ep_access_strobe <= 8'h10;
    @(posedge aclk);
    ep_access_strobe <= 8'h00;
    need(0, 6, 1'b0);
    rd(ADDR_EP_FLAGS, 32'h12);
    wr(ADDR_EP_FLAGS, 32'hFF);
    rd(ADDR_EP_FLAGS, 32'h00);
    mcu_stack_full <= 1'b1;
    reset_req <= 1'b1;
    need(0, 8, 1'b1);
    chk("service", 32'h0, usb_irq_service);
    @(posedge aclk);
    reset_req <= 1'b0;
    mcu_stack_full <= 1'b0;
    rd(ADDR_STATUS, 32'h18);
    wr(ADDR_STATUS, 32'h18);
    rd(ADDR_STATUS, 32'h10);
  endtask : access_events
  task pipe_toggle;
    wr(ADDR_PIPE_SEL, 32'h11);
    chk("toggle start", 32'h1, data_toggle[1]);
    chk("pipe select", 32'h9, {fifo_request, fifo_select});
    packet_done <= 8'h02;
    @(posedge aclk);
    packet_done <= 8'h00;
    @(negedge aclk);
    chk("toggle next", 32'h0, data_toggle[1]);
    wr(ADDR_PIPE_SEL, 32'h00);
    wr(8'h4C, 32'hA5);
    chk("pipe write", 32'h4, wresp_q);
    chk("tx pipe", 32'h3A5, {tx_ep, tx_data});
    rd(8'h4C, 32'hA5);
    rx_valid <= 1'b1;
    rx_ep <= 3'h5;
    rx_data <= 8'h3C;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rd(8'h54, 32'h3C);
    rd(8'h30, 32'h00);
    chk("unmapped resp", RESP_SLVERR, rresp_q);
    wr(8'h30, 32'h5A);
    chk("unmapped write", 32'h2, wresp_q);
  endtask : pipe_toggle
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    layout_cfg();
    suspend_entry();
    resume_wake();
    access_events();
    pipe_toggle();
    conclude();
  end
endmodule : usb_endpoint_fifo_and_suspend_ctrl_bench
